/* File: rtl/power_mode_reset_manager.sv */
`timescale 1ns/10ps
`default_nettype none
module power_mode_reset_manager #(
    parameter int PERIPH_W = 32
) (
    input  wire  logic                aclk,
    input  wire  logic                aresetn,
    input  wire  logic [7:0]          awaddr,
    input  wire  logic                awvalid,
    output logic                      awready,
    input  wire  logic [31:0]         wdata,
    input  wire  logic [3:0]          wstrb,
    input  wire  logic                wvalid,
    output logic                      wready,
    output logic [1:0]                bresp,
    output logic                      bvalid,
    input  wire  logic                bready,
    input  wire  logic [7:0]          araddr,
    input  wire  logic                arvalid,
    output logic                      arready,
    output logic [31:0]               rdata,
    output logic [1:0]                rresp,
    output logic                      rvalid,
    input  wire  logic                rready,
    input  wire  logic                wait_for_interrupt,
    input  wire  logic                wait_for_event,
    input  wire  logic                handler_return,
    input  wire  logic                deep_sleep_bit,
    input  wire  logic                sleep_on_exit_bit,
    input  wire  logic                irq_accepted,
    input  wire  logic                event_in,
    input  wire  logic                core_reset_request,
    input  wire  logic                watchdog_reset,
    input  wire  logic                main_monitor_reset,
    input  wire  logic                sub_monitor_reset,
    input  wire  logic                reset_pin_n,
    input  wire  logic                ext_irq,
    input  wire  logic                usart_receive_line,
    input  wire  logic                spi_receive_line,
    input  wire  logic                can_receive_line,
    input  wire  logic                lvd_reset_trip,
    input  wire  logic                lvd_irq_trip,
    output logic                      cpu_clk_en,
    output logic                      sys_clk_en,
    output logic [PERIPH_W-1:0]       periph_clk_en_a,
    output logic [PERIPH_W-1:0]       periph_clk_en_b,
    output logic [2:0]                system_clock_sel,
    output logic [3:0]                osc_en,
    output logic                      pll_en,
    output logic                      chip_reset_n,
    output logic                      lvi_pending,
    output logic [3:0]                power_mode,
    output logic                      low_voltage_reset_enable,
    output logic [2:0]                low_voltage_reset_level,
    output logic [2:0]                low_voltage_irq_level
);
    // Expand byte strobes to a bit mask
    function automatic logic [31:0] bmask(input logic [3:0] s);
        bmask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    pmr_pkg::pm_state_type state_r, st_nxt;
    logic [6:0]          sync1_r, sync2_r;
    logic                aw_hold_r, w_hold_r, bvalid_r, rvalid_r;
    logic                awready_r, wready_r, arready_r;
    logic [7:0]          aw_addr_r;
    logic [31:0]         w_data_r, rdata_r;
    logic [3:0]          w_strb_r;
    logic [1:0]          bresp_r, rresp_r;
    logic [31:0]         ctrl_r, ctrl_nxt, mode0_r;
    logic [PERIPH_W-1:0] pcs_a_r, pcs_b_r;
    logic [2:0]          sel_r, sel_nxt;
    logic                imsk_r, ris_r, event_r, wfe_entry_r, wfe_nxt;
    logic [7:0]          flags_r;
    logic [3:0]          cnt_r;
    logic                cpu_clk_en_r, sys_clk_en_r, pll_en_r, chip_reset_n_r, lvi_r;
    logic [PERIPH_W-1:0] pa_r, pb_r;
    logic [3:0]          osc_r;

    // Pin inputs pass two flops; only the second stage is read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_r <= pmr_pkg::SYNC_RST;
            sync2_r <= pmr_pkg::SYNC_RST;
        end else begin
            sync1_r <= {lvd_irq_trip, lvd_reset_trip, can_receive_line, spi_receive_line,
                        usart_receive_line, ext_irq, reset_pin_n};
            sync2_r <= sync1_r;
        end
    end
    wire pin_n_s   = sync2_r[0];
    wire rx_wake_s = sync2_r[1] | ~sync2_r[2] | ~sync2_r[3] | ~sync2_r[4];
    wire lvr_s     = sync2_r[5];
    wire lvi_s     = sync2_r[6];

    // Write channel: address and data taken in either order
    wire aw_take = awvalid & awready_r;
    wire w_take  = wvalid & wready_r;
    wire wr_do   = aw_hold_r & w_hold_r & ~bvalid_r;
    wire aw_hold_nxt = (aw_hold_r | aw_take) & ~wr_do;
    wire w_hold_nxt  = (w_hold_r | w_take) & ~wr_do;
    wire [31:0] wm   = w_data_r & bmask(w_strb_r);
    wire [31:0] keep = ~bmask(w_strb_r);
    wire wr_srst = wr_do & (aw_addr_r == pmr_pkg::OFF_SOFT_RST);
    wire wr_cset = wr_do & (aw_addr_r == pmr_pkg::OFF_CTRL_SET);
    wire wr_cclr = wr_do & (aw_addr_r == pmr_pkg::OFF_CTRL_CLR);
    wire wr_psa  = wr_do & (aw_addr_r == pmr_pkg::OFF_PCS_A);
    wire wr_psb  = wr_do & (aw_addr_r == pmr_pkg::OFF_PCS_B);
    wire wr_pca  = wr_do & (aw_addr_r == pmr_pkg::OFF_PCC_A);
    wire wr_pcb  = wr_do & (aw_addr_r == pmr_pkg::OFF_PCC_B);
    wire wr_mod0 = wr_do & (aw_addr_r == pmr_pkg::OFF_MODE0);
    wire wr_imsk = wr_do & (aw_addr_r == pmr_pkg::OFF_IRQ_MASK);
    wire wr_iclr = wr_do & (aw_addr_r == pmr_pkg::OFF_IRQ_CLR);
    wire wr_stat = wr_do & (aw_addr_r == pmr_pkg::OFF_STATUS);
    wire wr_csel = wr_do & (aw_addr_r == pmr_pkg::OFF_CLK_SEL);
    wire wr_hit  = wr_srst | wr_cset | wr_cclr | wr_psa | wr_psb | wr_pca | wr_pcb
                 | wr_mod0 | wr_imsk | wr_iclr | wr_stat | wr_csel;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= pmr_pkg::RESP_OKAY;
            aw_addr_r <= 8'h00;
            w_data_r  <= 32'h0000_0000;
            w_strb_r  <= 4'h0;
        end else begin
            aw_hold_r <= aw_hold_nxt;
            w_hold_r  <= w_hold_nxt;
            awready_r <= ~aw_hold_nxt;
            wready_r  <= ~w_hold_nxt;
            if (aw_take) aw_addr_r <= awaddr;
            if (w_take) begin
                w_data_r <= wdata;
                w_strb_r <= wstrb;
            end
            if (wr_do) begin
                bvalid_r <= 1'b1;
                bresp_r  <= wr_hit ? pmr_pkg::RESP_OKAY : pmr_pkg::RESP_SLVERR;
            end else if (bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // Read decode; unmapped reads return zero with an error answer
    wire run_st = (state_r == pmr_pkg::ST_NORMAL) | (state_r == pmr_pkg::ST_HIGH);
    wire [31:0] pad_a  = 32'(pcs_a_r);
    wire [31:0] pad_b  = 32'(pcs_b_r);
    wire [31:0] status = {flags_r, 19'h0, event_r, state_r};
    logic [31:0] rd_mux;
    logic        rd_hit;
    always_comb begin
        rd_hit = 1'b1;
        case (araddr)
            pmr_pkg::OFF_SOFT_RST: rd_mux = 32'h0000_0000;
            pmr_pkg::OFF_CTRL_SET: rd_mux = ctrl_r;
            pmr_pkg::OFF_PCS_A:    rd_mux = pad_a;
            pmr_pkg::OFF_PCS_B:    rd_mux = pad_b;
            pmr_pkg::OFF_MODE0:    rd_mux = mode0_r;
            pmr_pkg::OFF_IRQ_MASK: rd_mux = {31'h0, imsk_r};
            pmr_pkg::OFF_RAW_IRQ:  rd_mux = {31'h0, ris_r};
            pmr_pkg::OFF_MSK_IRQ:  rd_mux = {31'h0, ris_r & imsk_r};
            pmr_pkg::OFF_STATUS:   rd_mux = status;
            pmr_pkg::OFF_CLK_SEL:  rd_mux = {29'h0, sel_r};
            default: begin
                rd_mux = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
    end
    wire ar_take = arvalid & arready_r;
    wire rvalid_nxt = ar_take | (rvalid_r & ~rready);

    // Read answer is presented the cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r  <= 1'b0;
            arready_r <= 1'b0;
            rdata_r   <= 32'h0000_0000;
            rresp_r   <= pmr_pkg::RESP_OKAY;
        end else begin
            rvalid_r  <= rvalid_nxt;
            arready_r <= ~rvalid_nxt;
            if (ar_take) begin
                rdata_r <= rd_mux;
                rresp_r <= rd_hit ? pmr_pkg::RESP_OKAY : pmr_pkg::RESP_SLVERR;
            end
        end
    end

    // Reset sources in flag order; pin reset is unmaskable
    wire [7:0] src = {core_reset_request, main_monitor_reset, sub_monitor_reset, 1'b0,
                      watchdog_reset, lvr_s & mode0_r[pmr_pkg::B_LVR_EN], ~pin_n_s,
                      wr_srst & wm[0]};
    wire any_src = |src;
    wire crst    = (cnt_r != 4'h0);
    wire ctl_rst = ~aresetn | crst;
    wire [7:0] fclr = wr_stat ? wm[31:24] : 8'h00;
    // Other resets drop all but power-on and low-voltage flags; set beats clear
    wire [7:0] flags_nxt = any_src ? ((flags_r & pmr_pkg::FLAG_KEEP & ~fclr) | src)
                                   : (flags_r & ~fclr);

    // Flags survive chip resets; power-on loads FLAG_RST, status writes clear them
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_r <= pmr_pkg::FLAG_RST;
            cnt_r   <= 4'h0;
        end else begin
            flags_r <= flags_nxt;
            if (any_src) cnt_r <= 4'(pmr_pkg::RST_HOLD_CYC);
            else if (crst) cnt_r <= cnt_r - 4'h1;
        end
    end

    // Sleep entry from the core's sleep signals
    wire wfe_sleep = wait_for_event & ~event_r;
    wire go_sleep  = run_st & (wait_for_interrupt | wfe_sleep
                   | (handler_return & sleep_on_exit_bit));
    wire idle_wake = irq_accepted | (wfe_entry_r & event_in);
    wire stop_wake = (state_r == pmr_pkg::ST_STOP) & rx_wake_s;
    wire fast_wake = stop_wake & ctrl_r[pmr_pkg::B_FAST_WAKEUP];
    wire [31:0] cset = wr_cset ? (wm & pmr_pkg::CTRL_WMASK) : 32'h0000_0000;
    wire [31:0] cclr = wr_cclr ? (wm & pmr_pkg::CTRL_WMASK) : 32'h0000_0000;

    // Fast wakeup forces internal main oscillator on and selects it
    always_comb begin
        ctrl_nxt = (ctrl_r | cset) & ~cclr;
        if (fast_wake) ctrl_nxt[pmr_pkg::B_INT_MAIN] = 1'b1;
        sel_nxt = wr_csel ? wm[2:0] : sel_r;
        if (fast_wake) sel_nxt = pmr_pkg::SEL_INT_MAIN;
    end
    wire [3:0] run_code = (sel_nxt == pmr_pkg::SEL_PLL) ? pmr_pkg::ST_HIGH : pmr_pkg::ST_NORMAL;

    // Mode machine; stop is reachable only from a running state
    always_comb begin
        st_nxt  = state_r;
        wfe_nxt = wfe_entry_r;
        case (state_r)
            pmr_pkg::ST_NORMAL, pmr_pkg::ST_HIGH: begin
                if (go_sleep) begin
                    st_nxt  = deep_sleep_bit ? pmr_pkg::ST_STOP : pmr_pkg::ST_IDLE;
                    wfe_nxt = wait_for_event & ~wait_for_interrupt;
                end else begin
                    st_nxt = pmr_pkg::pm_state_type'(run_code);
                end
            end
            pmr_pkg::ST_IDLE: begin
                if (idle_wake) st_nxt = pmr_pkg::pm_state_type'(run_code);
            end
            pmr_pkg::ST_STOP: begin
                if (stop_wake) st_nxt = pmr_pkg::pm_state_type'(run_code);
            end
            default: st_nxt = pmr_pkg::ST_NORMAL;
        endcase
    end

    // Control state returns to defaults on every chip reset
    always_ff @(posedge aclk) begin
        if (ctl_rst) begin
            state_r     <= pmr_pkg::ST_NORMAL;
            wfe_entry_r <= 1'b0;
            event_r     <= 1'b0;
            ctrl_r      <= pmr_pkg::CTRL_RST;
            sel_r       <= pmr_pkg::SEL_INT_MAIN;
            mode0_r     <= pmr_pkg::MODE0_RST;
            pcs_a_r     <= '0;
            pcs_b_r     <= '0;
            imsk_r      <= 1'b0;
            ris_r       <= 1'b0;
        end else begin
            state_r     <= st_nxt;
            wfe_entry_r <= wfe_nxt;
            event_r     <= event_in | (event_r & ~(run_st & wait_for_event));
            ctrl_r      <= ctrl_nxt;
            sel_r       <= sel_nxt;
            if (wr_mod0) mode0_r <= ((mode0_r & keep) | wm) & pmr_pkg::MODE0_MASK;
            if (wr_psa) pcs_a_r <= pcs_a_r | wm[PERIPH_W-1:0];
            else if (wr_pca) pcs_a_r <= pcs_a_r & ~wm[PERIPH_W-1:0];
            if (wr_psb) pcs_b_r <= pcs_b_r | wm[PERIPH_W-1:0];
            else if (wr_pcb) pcs_b_r <= pcs_b_r & ~wm[PERIPH_W-1:0];
            if (wr_imsk) imsk_r <= wm[pmr_pkg::B_LVI];
            // Trip beats a clear in the same cycle
            ris_r <= (lvi_s & mode0_r[pmr_pkg::B_LVI_EN])
                   | (ris_r & ~(wr_iclr & wm[pmr_pkg::B_LVI]));
        end
    end

    // Clock gates and oscillator enables follow the next mode
    wire nx_run  = (st_nxt == pmr_pkg::ST_NORMAL) | (st_nxt == pmr_pkg::ST_HIGH);
    wire nx_idle = (st_nxt == pmr_pkg::ST_IDLE);
    wire nx_stop = (st_nxt == pmr_pkg::ST_STOP) & ~any_src;
    wire pcut    = nx_stop | (nx_idle & ctrl_nxt[pmr_pkg::B_PCLK]);
    wire sub_run = ctrl_nxt[pmr_pkg::B_INT_SUB] & (~nx_stop | ctrl_nxt[pmr_pkg::B_SUB_KEEP]);
    always_ff @(posedge aclk) begin
        if (ctl_rst) begin
            cpu_clk_en_r <= 1'b1;
            sys_clk_en_r <= 1'b1;
            pa_r         <= '0;
            pb_r         <= '0;
            osc_r        <= pmr_pkg::CTRL_RST[3:0];
            pll_en_r     <= 1'b0;
            lvi_r        <= 1'b0;
        end else begin
            cpu_clk_en_r <= nx_run & ~any_src;
            sys_clk_en_r <= ~nx_stop;
            pa_r         <= pcut ? '0 : pcs_a_r;
            pb_r         <= pcut ? '0 : pcs_b_r;
            osc_r        <= nx_stop ? {sub_run, 3'b000} : {sub_run, ctrl_nxt[2:0]};
            pll_en_r     <= ctrl_nxt[pmr_pkg::B_PLL] & ~nx_stop;
            lvi_r        <= ris_r & imsk_r;
        end
    end

    // Chip reset output is low while any source or the hold lasts
    always_ff @(posedge aclk) begin
        if (!aresetn) chip_reset_n_r <= 1'b0;
        else chip_reset_n_r <= ~(any_src | (cnt_r > 4'h1));
    end

    assign awready = awready_r;
    assign wready  = wready_r;
    assign bvalid  = bvalid_r;
    assign bresp   = bresp_r;
    assign arready = arready_r;
    assign rvalid  = rvalid_r;
    assign rdata   = rdata_r;
    assign rresp   = rresp_r;
    assign cpu_clk_en       = cpu_clk_en_r;
    assign sys_clk_en       = sys_clk_en_r;
    assign periph_clk_en_a  = pa_r;
    assign periph_clk_en_b  = pb_r;
    assign system_clock_sel = sel_r;
    assign osc_en           = osc_r;
    assign pll_en           = pll_en_r;
    assign chip_reset_n     = chip_reset_n_r;
    assign lvi_pending      = lvi_r;
    assign power_mode       = state_r;
    assign low_voltage_reset_enable = mode0_r[pmr_pkg::B_LVR_EN];
    assign low_voltage_reset_level  = mode0_r[pmr_pkg::B_LVR_LVL +: 3];
    assign low_voltage_irq_level    = mode0_r[pmr_pkg::B_LVI_LVL +: 3];

    // Checks on mode, clock and reset behaviour
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire quiet = ~any_src & ~crst;
    stop_from_run_a: assert property ($rose(state_r == pmr_pkg::ST_STOP) && !crst
        |-> $past(state_r) != pmr_pkg::ST_IDLE) else $error("stop entered from idle");
    wfe_skip_a: assert property (run_st && wait_for_event && !wait_for_interrupt && event_r && !event_in
        && !handler_return && quiet |=> run_st && !event_r) else $error("event bit not consumed");
    wfi_idle_a: assert property (run_st && wait_for_interrupt && !deep_sleep_bit && quiet
        |=> state_r == pmr_pkg::ST_IDLE ##0 !cpu_clk_en) else $error("no idle entry");
    deep_stop_a: assert property (run_st && wait_for_interrupt && deep_sleep_bit && quiet
        |=> state_r == pmr_pkg::ST_STOP) else $error("no stop entry");
    idle_cpu_a: assert property (state_r == pmr_pkg::ST_IDLE && !idle_wake && quiet
        |=> !cpu_clk_en) else $error("cpu clock runs in idle");
    stop_osc_a: assert property (state_r == pmr_pkg::ST_STOP && !stop_wake && quiet
        |=> !sys_clk_en && osc_en[2:0] == 3'b000 && !pll_en) else $error("clock alive in stop");
    fast_sel_a: assert property (fast_wake && quiet
        |=> system_clock_sel == pmr_pkg::SEL_INT_MAIN && osc_en[1]) else $error("fast wakeup clock");
    pin_rst_a: assert property (!pin_n_s |=> !chip_reset_n && flags_r[pmr_pkg::F_PIN])
        else $error("pin reset missed");
    flag_keep_a: assert property (any_src && !wr_stat |=> flags_r[pmr_pkg::F_POR] == $past(flags_r[pmr_pkg::F_POR])
        && (flags_r[pmr_pkg::F_WDT] == $past(src[pmr_pkg::F_WDT]))) else $error("flag update wrong");
    lvi_a: assert property (ris_r && imsk_r && quiet |=> lvi_pending) else $error("low-voltage irq lost");
    idle_enter_c: cover property (run_st ##1 state_r == pmr_pkg::ST_IDLE ##[1:20] run_st);
    stop_wake_c: cover property (state_r == pmr_pkg::ST_STOP ##[1:20] stop_wake);
    soft_rst_c: cover property (wr_srst && wm[0] ##1 !chip_reset_n);
    lvi_raise_c: cover property (lvi_s && mode0_r[pmr_pkg::B_LVI_EN] ##2 lvi_pending);
endmodule // power_mode_reset_manager
`default_nettype wire

/* File: include/pmr_pkg.sv */
// Notes on behaviour
// - Normal mode: oscillator clock, per-peripheral gating bits.
// - High-speed mode feeds PLL clock everywhere.
// - Idle stops processor clock; peripheral cut optional.
// - Stop halts all; sub oscillator optional; pin wakeups.
// - Stop entered only from normal or high-speed.
// - Wait-for-event: event bit set skips sleeping.
// - Wait-for-interrupt sleeps at once.
// - Both core bits clear: immediate idle, no latency.
// - Sleep-on-exit alone: idle on handler return.
// - Idle wake: accepted interrupt, or event if entered by wfe.
// - Deep-sleep bit selects stop on entry.
// - Stop disconnects system clock, halts oscillators.
// - Wakeup restores prior oscillators; fast wakeup adds main.
// - Eight last-reset flags in status bits 24-31.
// - Flag order: soft,pin,lowvolt,watchdog,poweron,sub,main,core.
// - Software clears flags; resets keep power-on, low-voltage.
// - Reset pin low forces unmaskable reset, sets flag.
// - Low-voltage reset on by default, 3-bit level.
// - Low-voltage interrupt: enable, mask, pending, clear.
// - Soft, watchdog, core requests reset chip, set flags.
// - Fast wakeup makes internal main the system clock.
package pmr_pkg;
    localparam logic [7:0]  OFF_SOFT_RST  = 8'h04;
    localparam logic [7:0]  OFF_CTRL_SET  = 8'h08;
    localparam logic [7:0]  OFF_CTRL_CLR  = 8'h0C;
    localparam logic [7:0]  OFF_PCS_A     = 8'h10;
    localparam logic [7:0]  OFF_PCS_B     = 8'h14;
    localparam logic [7:0]  OFF_PCC_A     = 8'h18;
    localparam logic [7:0]  OFF_PCC_B     = 8'h1C;
    localparam logic [7:0]  OFF_MODE0     = 8'h28;
    localparam logic [7:0]  OFF_IRQ_MASK  = 8'h30;
    localparam logic [7:0]  OFF_RAW_IRQ   = 8'h34;
    localparam logic [7:0]  OFF_MSK_IRQ   = 8'h38;
    localparam logic [7:0]  OFF_IRQ_CLR   = 8'h3C;
    localparam logic [7:0]  OFF_STATUS    = 8'h40;
    localparam logic [7:0]  OFF_CLK_SEL   = 8'hB0;
    // Control set/clear bit positions
    localparam int B_EXT_MAIN = 0;
    localparam int B_INT_MAIN = 1;
    localparam int B_EXT_SUB  = 2;
    localparam int B_INT_SUB  = 3;
    localparam int B_FAST_WAKEUP    = 5;
    localparam int B_PLL      = 7;
    localparam int B_PCLK     = 9;
    localparam int B_SUB_KEEP = 10;
    localparam int B_IDLE_WAKEUP_SELECT    = 11;
    localparam logic [31:0] CTRL_WMASK = 32'h0000_0EAF;
    localparam logic [31:0] CTRL_RST   = 32'h0000_0002;
    // Mode register 0 fields
    localparam int B_LVR_LVL  = 0;
    localparam int B_LVR_EN   = 3;
    localparam int B_LVI_EN   = 4;
    localparam int B_LVI_LVL  = 8;
    localparam logic [31:0] MODE0_RST  = 32'h0000_0008;
    localparam logic [31:0] MODE0_MASK = 32'h0000_071F;
    localparam int B_LVI      = 0;
    // Reset flag positions inside the flag byte (status bit = 24 + n)
    localparam int FLAG_LSB   = 24;
    localparam int F_SOFT     = 0;
    localparam int F_PIN      = 1;
    localparam int F_LVR      = 2;
    localparam int F_WDT      = 3;
    localparam int F_POR      = 4;
    localparam int F_SUBMON   = 5;
    localparam int F_MAINMON  = 6;
    localparam int F_CORE     = 7;
    localparam logic [7:0]  FLAG_KEEP = 8'h14;
    localparam logic [7:0]  FLAG_RST  = 8'h10;
    // System clock source codes
    localparam logic [2:0]  SEL_EXT_MAIN = 3'h0;
    localparam logic [2:0]  SEL_INT_MAIN = 3'h1;
    localparam logic [2:0]  SEL_EXT_SUB  = 3'h2;
    localparam logic [2:0]  SEL_INT_SUB  = 3'h3;
    localparam logic [2:0]  SEL_PLL      = 3'h4;
    localparam logic [6:0]  SYNC_RST     = 7'h1D;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;
    localparam int CLK_NS       = 100;
    localparam int RST_HOLD_NS  = 1000;
    localparam int RST_HOLD_CYC = (RST_HOLD_NS + CLK_NS - 1) / CLK_NS;
    typedef enum logic [3:0] {
        ST_NORMAL = 4'b0001,
        ST_HIGH   = 4'b0010,
        ST_IDLE   = 4'b0100,
        ST_STOP   = 4'b1000
    } pm_state_type;
endpackage

/* File: dv/core_model.sv */
`timescale 1ns/10ps
`default_nettype none
module core_model (
    input  wire logic       aclk,
    output logic      [4:0] req,
    output logic      [1:0] bits
);
    // Pulses {wfi, wfe, return, accepted, event}; bits {deep, exit}
    initial req = 5'h00;
    initial bits = 2'h0;
    task automatic go(input logic [4:0] p, input logic [1:0] b);
        @(posedge aclk);
        req <= p;
        bits <= b;
        @(posedge aclk);
        req <= 5'h00; // Single cycle, never stretched
    endtask
endmodule // core_model
`default_nettype wire

/* File: dv/power_mode_reset_manager_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module power_mode_reset_manager_tb;
    logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, reset_pin_n = 1'b1, lvi = 1'b0, lvp;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rd_v, pca;
    logic [4:0]  src = 5'h00;
    logic [3:0]  wk = 4'h0, osc_en, power_mode;
    logic [1:0]  bresp, rresp, rr;
    logic [31:0] rdata;
    logic [2:0]  system_clock_sel;
    logic        awready, wready, bvalid, arready, rvalid, cpu_clk_en, sys_clk_en, chip_reset_n;
    wire  [4:0]  rq;
    wire  [1:0]  cb;
    int          n_fail = 0, n_compared = 0, i;
    // Expected flag byte per reset source, lvr flag persists after source 4
    logic [7:0]  fl [7] = '{8'h80, 8'h08, 8'h40, 8'h20, 8'h04, 8'h05, 8'h06};
    always #50 aclk = ~aclk;
    core_model core (.aclk(aclk), .req(rq), .bits(cb));
    power_mode_reset_manager uut (.wstrb(4'hF), .wait_for_interrupt(rq[4]), .wait_for_event(rq[3]),
        .handler_return(rq[2]), .irq_accepted(rq[1]), .event_in(rq[0]), .deep_sleep_bit(cb[1]),
        .sleep_on_exit_bit(cb[0]), .core_reset_request(src[0]), .watchdog_reset(src[1]),
        .main_monitor_reset(src[2]), .sub_monitor_reset(src[3]), .lvd_reset_trip(src[4]),
        .ext_irq(wk[0]), .usart_receive_line(~wk[1]), .spi_receive_line(~wk[2]),
        .can_receive_line(~wk[3]), .lvd_irq_trip(lvi), .periph_clk_en_a(pca), .periph_clk_en_b(),
        .pll_en(), .lvi_pending(lvp), .low_voltage_reset_enable(), .low_voltage_reset_level(),
        .low_voltage_irq_level(), .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .reset_pin_n(reset_pin_n), .cpu_clk_en(cpu_clk_en),
        .sys_clk_en(sys_clk_en), .system_clock_sel(system_clock_sel), .osc_en(osc_en),
        .chip_reset_n(chip_reset_n), .power_mode(power_mode));
    task automatic end_of_test();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            n_fail++;
            $display("mismatch at %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic tmo();
        n_fail++;
        end_of_test();
    endtask
    // Bus write: address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'h7;
        for (int k = 0; k < 50; k++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                bready <= 1'b0;
                return;
            end
        end
        tmo();
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        for (int k = 0; k < 50; k++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                rd_v = rdata;
                rr = rresp;
                rready <= 1'b0;
                chk(rd_v, e);
                return;
            end
        end
        tmo();
    endtask
    // Bounded wait on power mode (s=0) or chip reset (s=1)
    task automatic wt(input int s, input logic [3:0] v);
        for (int k = 0; k < 60; k++) begin
            @(posedge aclk);
            if ((s ? {3'h0, chip_reset_n} : power_mode) === v) return;
        end
        tmo();
    endtask
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rdc(pmr_pkg::OFF_STATUS, {pmr_pkg::FLAG_RST, 24'h000001});
        rdc(pmr_pkg::OFF_MODE0, pmr_pkg::MODE0_RST);
        rdc(8'hFC, 32'h0);
        chk({30'h0, rr}, {30'h0, pmr_pkg::RESP_SLVERR});
        // Gate output follows the set register one cycle later
        wr(pmr_pkg::OFF_PCS_A, 32'h0000_00A5);
        @(posedge aclk);
        chk(pca, 32'h0000_00A5);
        // Low-voltage interrupt: enable, unmask, trip, then clear once the trip is gone
        wr(pmr_pkg::OFF_MODE0, 32'h0000_0018);
        wr(pmr_pkg::OFF_IRQ_MASK, 32'h0000_0001);
        lvi <= 1'b1;
        repeat (6) @(posedge aclk);
        chk(lvp, 1'b1);
        lvi <= 1'b0;
        repeat (3) @(posedge aclk);
        wr(pmr_pkg::OFF_IRQ_CLR, 32'h0000_0001);
        repeat (2) @(posedge aclk);
        chk(lvp, 1'b0);
        core.go(5'h10, 2'h0);
        wt(0, pmr_pkg::ST_IDLE);
        chk(cpu_clk_en, 1'b0);
        core.go(5'h10, 2'h2);
        repeat (3) @(posedge aclk);
        chk(power_mode, pmr_pkg::ST_IDLE);
        core.go(5'h02, 2'h0);
        wt(0, pmr_pkg::ST_NORMAL);
        core.go(5'h01, 2'h0);
        core.go(5'h08, 2'h0);
        repeat (3) @(posedge aclk);
        chk(power_mode, pmr_pkg::ST_NORMAL);
        core.go(5'h08, 2'h0);
        wt(0, pmr_pkg::ST_IDLE);
        core.go(5'h01, 2'h0);
        wt(0, pmr_pkg::ST_NORMAL);
        core.go(5'h04, 2'h1);
        wt(0, pmr_pkg::ST_IDLE);
        core.go(5'h02, 2'h0);
        wr(pmr_pkg::OFF_CTRL_SET, 32'h21);
        wr(pmr_pkg::OFF_CTRL_CLR, 32'h2);
        // First stop is entered from high-speed mode
        wr(pmr_pkg::OFF_CLK_SEL, 32'h4);
        wt(0, pmr_pkg::ST_HIGH);
        // Stop by return and by wfi, woken by each pin in turn
        for (i = 0; i < 4; i++) begin
            core.go(i ? 5'h10 : 5'h04, {1'b1, i == 0});
            wt(0, pmr_pkg::ST_STOP);
            chk(sys_clk_en, 1'b0);
            wk <= 4'h1 << i;
            wt(0, pmr_pkg::ST_NORMAL);
            wk <= 4'h0;
            chk(osc_en, 4'h3);
            chk(system_clock_sel, pmr_pkg::SEL_INT_MAIN);
        end
        wr(pmr_pkg::OFF_STATUS, 32'hFF00_0000);
        // Event that woke idle earlier is still held in the event bit
        rdc(pmr_pkg::OFF_STATUS, 32'h11);
        for (i = 0; i < 7; i++) begin
            if (i < 5) src <= 5'h01 << i;
            else if (i == 5) wr(pmr_pkg::OFF_SOFT_RST, 32'h1);
            else reset_pin_n <= 1'b0;
            wt(1, 4'h0);
            {src, reset_pin_n} <= 6'h01;
            wt(1, 4'h1);
            rdc(pmr_pkg::OFF_STATUS, {fl[i], 24'h000001});
        end
        end_of_test();
    end
endmodule // power_mode_reset_manager_tb
`default_nettype wire
